// File: timer_defs.svh
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// register byte offsets on the avalon slave
`define OFS_COUNT_CONTROL  5'h00
`define OFS_MODE_CONTROL   5'h04
`define OFS_COUNTER_LOW    5'h08
`define OFS_COUNTER_HIGH   5'h0c
`define OFS_COMPARE_A_LOW  5'h10
`define OFS_COMPARE_A_HIGH 5'h14
`define OFS_COMPARE_P_HIGH 5'h18

// reset values
`define RST_COUNT_CONTROL  8'h00
`define RST_MODE_CONTROL   8'h00
`define RST_COMPARE        8'h00

// operating mode codes
`define MODE_COMPARE       2'h0
`define MODE_CAPTURE       2'h1
`define MODE_PWM           2'h2
`define MODE_TIMER         2'h3

// count clock select codes
`define CLK_SYS_DIV4       3'h0
`define CLK_SYS            3'h1
`define CLK_HIGH_DIV16     3'h2
`define CLK_HIGH_DIV64     3'h3
`define CLK_SUB            3'h4
`define CLK_RESERVED       3'h5
`define CLK_PIN_RISE       3'h6
`define CLK_PIN_FALL       3'h7

// pin function codes
`define PIN_FN_0           2'h0
`define PIN_FN_1           2'h1
`define PIN_FN_2           2'h2
`define PIN_FN_3           2'h3

// field position of the on/off bit in count_control
`define CC_ON_BIT          3

// prescaler widths
`define PRESCALE_BITS      6

`endif

// File: timer_pkg.sv
package timer_pkg;

    // count_control layout, msb first
    typedef struct packed {
        logic       pause_bit;
        logic [2:0] count_clock_select;
        logic       counter_on_bit;
        logic [2:0] unused;
    } count_ctrl_t;

    // mode_control layout, msb first
    typedef struct packed {
        logic [1:0] operating_mode_field;
        logic [1:0] pin_function_field;
        logic       output_control_bit;
        logic       output_polarity_bit;
        logic       period_duty_select;
        logic       clear_source_select;
    } mode_ctrl_t;

endpackage

// File: pin_edge.sv
`timescale 1ns/1ps
// two-flop synchroniser followed by edge detection
module pin_edge (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    logic meta;
    logic sync;
    logic last;

    // meta feeds only sync
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= 1'b0;
            sync <= 1'b0;
            last <= 1'b0;
        end else if (ce) begin
            meta <= pin;
            sync <= meta;
            last <= sync;
        end
    end

    // single-cycle edge pulses
    assign rise = ce & sync & ~last;
    assign fall = ce & ~sync & last;
endmodule

// File: prescaler.sv
`timescale 1ns/1ps
`include "timer_defs.svh"
// free-running divider giving one-cycle count ticks
module prescaler (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic ce,
    output logic      tick_div4,
    output logic      tick_div16,
    output logic      tick_div64
);
    logic [`PRESCALE_BITS-1:0] div;

    // divider advances every enabled cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div <= '0;
        end else if (ce) begin
            div <= div + 1'b1;
        end
    end

    // ticks on the last step of each ratio
    assign tick_div4  = ce & (&div[1:0]);
    assign tick_div16 = ce & (&div[3:0]);
    assign tick_div64 = ce & (&div[5:0]);
endmodule

// File: standard_timer.sv
// Overview of operation
// - 16-bit up-counter; comparator A on all bits, P on the upper byte
// - software never writes the counter; an on-bit rise or a clear event clears it
// - overflow or selected comparator match clears counter and raises a flag
// - pause bit holds the counter; clearing it resumes from the held value
// - clock select picks sys/4, sys, high/16, high/64, sub, stop, pin edges
// - on-bit low stops and keeps count; its rise resets the counter to zero
// - in compare mode an on-bit rise restores the pin's initial level
// - mode field: compare, capture, pwm or single pulse, timer/counter
// - compare mode A match: hold, drive low, drive high or toggle pin
// - pwm mode pin: inactive, active, pwm output, single pulse output
// - capture mode trigger: rising, falling, either edge, or disabled
// - requested level equal to initial level gives no visible pin change
// - output control bit: initial level in compare, active level in pwm
// - polarity bit inverts the pin; ignored in timer/counter mode
// - period/duty select swaps roles of comparator P and A values
// - clear source: A match, or P match / overflow when P value is zero
// - clear source bit ignored in pwm, single pulse and capture modes
// - timer/counter mode disables pin control entirely
// - low three bits of count_control always read as zero
// - with A as clear source in compare or timer mode, no P flag
// - P value zero gives 65536 clocks, else 256 times the value
// - pwm duty at or above period gives full duty output
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "timer_defs.svh"
module standard_timer (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic [4:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        external_count_pin,
    input  wire logic        sub_clock_pin,
    input  wire logic        timer_io_pin_i,
    output logic             timer_io_pin_o,
    output logic             timer_io_pin_oe,
    output logic             compare_a_flag,
    output logic             compare_p_flag
);
    import timer_pkg::*;

    timer_pkg::count_ctrl_t cc;
    timer_pkg::mode_ctrl_t  mc;
    logic [15:0] compare_a_value;
    logic [7:0]  compare_p_value;
    logic [15:0] count;
    logic        out_state;
    logic        pulse_active;

    logic        tick_div4;
    logic        tick_div16;
    logic        tick_div64;
    logic        ext_rise;
    logic        ext_fall;
    logic        sub_rise;
    logic        io_rise;
    logic        io_fall;

    // clock sources
    prescaler u_prescaler (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .tick_div4  (tick_div4),
        .tick_div16 (tick_div16),
        .tick_div64 (tick_div64)
    );

    pin_edge u_ext_edge (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .pin  (external_count_pin),
        .rise (ext_rise),
        .fall (ext_fall)
    );

    pin_edge u_sub_edge (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .pin  (sub_clock_pin),
        .rise (sub_rise),
        .fall ()
    );

    pin_edge u_io_edge (
        .clk  (clk),
        .rst  (rst),
        .ce   (ce),
        .pin  (timer_io_pin_i),
        .rise (io_rise),
        .fall (io_fall)
    );

    // bus decode: write lands at the edge where waitrequest is low
    logic bus_wr;
    logic bus_rd_load;
    logic on_rise;
    assign bus_wr      = ce & write & ~waitrequest & byteenable[0];
    assign bus_rd_load = ce & read & waitrequest;
    assign on_rise     = bus_wr & (address == `OFS_COUNT_CONTROL)
                         & writedata[`CC_ON_BIT] & ~cc.counter_on_bit;

    // count tick selection
    logic tick;
    always_comb begin
        case (cc.count_clock_select)
            `CLK_SYS_DIV4:   tick = tick_div4;
            `CLK_SYS:        tick = ce;
            `CLK_HIGH_DIV16: tick = tick_div16;
            `CLK_HIGH_DIV64: tick = tick_div64;
            `CLK_SUB:        tick = sub_rise;
            `CLK_PIN_RISE:   tick = ext_rise;
            `CLK_PIN_FALL:   tick = ext_fall;
            default:         tick = 1'b0;
        endcase
    end

    // comparators look at the value the counter would take next
    logic        run;
    logic [16:0] next_count;
    logic        a_hit;
    logic        p_hit;
    logic        overflow;
    logic        cmp_like;
    assign run        = cc.counter_on_bit & ~cc.pause_bit & tick;
    assign next_count = {1'b0, count} + 17'h00001;
    assign overflow   = next_count[16];
    assign a_hit      = next_count[15:0] == compare_a_value;
    assign p_hit      = (next_count[15:8] == compare_p_value)
                        & (next_count[7:0] == 8'h00);
    assign cmp_like   = (mc.operating_mode_field == `MODE_COMPARE)
                        | (mc.operating_mode_field == `MODE_TIMER);

    // clear condition per mode
    logic clear_now;
    always_comb begin
        case (mc.operating_mode_field)
            `MODE_COMPARE, `MODE_TIMER:
                clear_now = mc.clear_source_select ? a_hit : p_hit;
            `MODE_PWM:
                clear_now = mc.period_duty_select ? a_hit : p_hit;
            default:
                clear_now = overflow;
        endcase
    end

    // capture trigger from the timer pin
    logic capture_now;
    always_comb begin
        case (mc.pin_function_field)
            `PIN_FN_0: capture_now = io_rise;
            `PIN_FN_1: capture_now = io_fall;
            `PIN_FN_2: capture_now = io_rise | io_fall;
            default:   capture_now = 1'b0;
        endcase
        capture_now = capture_now & cc.counter_on_bit
                      & (mc.operating_mode_field == `MODE_CAPTURE);
    end

    // counter: no bus write path, cleared by on-bit rise or clear event
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count <= 16'h0000;
        end else if (ce) begin
            if (on_rise) begin
                count <= 16'h0000;
            end else if (run) begin
                count <= clear_now ? 16'h0000 : next_count[15:0];
            end
        end
    end

    // control registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cc <= `RST_COUNT_CONTROL;
            mc <= `RST_MODE_CONTROL;
        end else if (bus_wr) begin
            if (address == `OFS_COUNT_CONTROL) begin
                cc <= {writedata[7:3], 3'h0};
            end
            if (address == `OFS_MODE_CONTROL) begin
                mc <= writedata[7:0];
            end
        end
    end

    // compare values; a capture takes precedence over a bus write
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_a_value <= {`RST_COMPARE, `RST_COMPARE};
            compare_p_value <= `RST_COMPARE;
        end else if (ce) begin
            if (capture_now) begin
                compare_a_value <= count;
            end else if (bus_wr && address == `OFS_COMPARE_A_LOW) begin
                compare_a_value[7:0] <= writedata[7:0];
            end else if (bus_wr && address == `OFS_COMPARE_A_HIGH) begin
                compare_a_value[15:8] <= writedata[7:0];
            end
            if (bus_wr && address == `OFS_COMPARE_P_HIGH) begin
                compare_p_value <= writedata[7:0];
            end
        end
    end

    // match flags, one-cycle pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            compare_a_flag <= 1'b0;
            compare_p_flag <= 1'b0;
        end else if (ce) begin
            if (mc.operating_mode_field == `MODE_CAPTURE) begin
                compare_a_flag <= capture_now;
                compare_p_flag <= run & overflow;
            end else begin
                compare_a_flag <= run & a_hit;
                compare_p_flag <= run & p_hit
                                  & ~(cmp_like & mc.clear_source_select);
            end
        end
    end

    // pwm period and duty, 17 bits so that zero P means 65536
    logic [16:0] p_span;
    logic [16:0] period;
    logic [16:0] duty;
    logic        pwm_on;
    assign p_span = (compare_p_value == 8'h00) ? 17'h10000 : {1'b0, compare_p_value, 8'h00};
    assign period = mc.period_duty_select ? {1'b0, compare_a_value} : p_span;
    assign duty   = mc.period_duty_select ? p_span : {1'b0, compare_a_value};
    assign pwm_on = ({1'b0, count} < duty) | (duty >= period);

    // compare-mode pin state and single-pulse window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_state    <= 1'b0;
            pulse_active <= 1'b0;
        end else if (ce) begin
            if (on_rise) begin
                out_state    <= mc.output_control_bit;
                pulse_active <= 1'b1;
            end else begin
                if (run && clear_now) begin
                    pulse_active <= 1'b0;
                end
                if (run && a_hit && mc.operating_mode_field == `MODE_COMPARE) begin
                    case (mc.pin_function_field)
                        `PIN_FN_1: out_state <= 1'b0;
                        `PIN_FN_2: out_state <= 1'b1;
                        `PIN_FN_3: out_state <= ~out_state;
                        default:   out_state <= out_state;
                    endcase
                end
            end
        end
    end

    // pin level before polarity
    logic level;
    always_comb begin
        case (mc.pin_function_field)
            `PIN_FN_0: level = ~mc.output_control_bit;
            `PIN_FN_1: level = mc.output_control_bit;
            `PIN_FN_2: level = pwm_on ? mc.output_control_bit : ~mc.output_control_bit;
            default:   level = (pulse_active & pwm_on & cc.counter_on_bit)
                               ? mc.output_control_bit : ~mc.output_control_bit;
        endcase
        if (mc.operating_mode_field == `MODE_COMPARE) begin
            level = out_state;
        end
    end

    // registered pin drive
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            timer_io_pin_o  <= 1'b0;
            timer_io_pin_oe <= 1'b0;
        end else if (ce) begin
            timer_io_pin_o  <= level ^ mc.output_polarity_bit;
            timer_io_pin_oe <= (mc.operating_mode_field == `MODE_COMPARE)
                               | (mc.operating_mode_field == `MODE_PWM);
        end
    end

    // avalon slave: one wait cycle, then the answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitrequest <= 1'b1;
        end else if (ce) begin
            waitrequest <= ~((read | write) & waitrequest);
        end
    end

    // read data loaded in the wait cycle, unmapped reads zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            readdata <= 32'h00000000;
        end else if (bus_rd_load) begin
            case (address)
                `OFS_COUNT_CONTROL:  readdata <= {24'h000000, cc[7:3], 3'h0};
                `OFS_MODE_CONTROL:   readdata <= {24'h000000, mc};
                `OFS_COUNTER_LOW:    readdata <= {24'h000000, count[7:0]};
                `OFS_COUNTER_HIGH:   readdata <= {24'h000000, count[15:8]};
                `OFS_COMPARE_A_LOW:  readdata <= {24'h000000, compare_a_value[7:0]};
                `OFS_COMPARE_A_HIGH: readdata <= {24'h000000, compare_a_value[15:8]};
                `OFS_COMPARE_P_HIGH: readdata <= {24'h000000, compare_p_value};
                default:             readdata <= 32'h00000000;
            endcase
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    reserved_bits_a: assert property (
        (ce && read && waitrequest && address == `OFS_COUNT_CONTROL)
        |=> readdata[2:0] == 3'h0 && !waitrequest)
        else $error("count_control low bits not zero");

    on_clear_a: assert property (
        on_rise |=> count == 16'h0000)
        else $error("on-bit rise did not clear counter");

    pause_hold_a: assert property (
        (cc.pause_bit && !on_rise) |=> $stable(count))
        else $error("counter moved while paused");

    off_hold_a: assert property (
        (!cc.counter_on_bit && !on_rise) |=> $stable(count))
        else $error("counter moved while off");

    reserved_clock_a: assert property (
        (cc.count_clock_select == `CLK_RESERVED && !on_rise) |=> $stable(count))
        else $error("reserved clock advanced counter");

    match_clear_a: assert property (
        (ce && run && clear_now && !on_rise) |=> count == 16'h0000)
        else $error("counter not cleared on match");

    p_flag_block_a: assert property (
        (ce && cmp_like && mc.clear_source_select) |=> !compare_p_flag)
        else $error("comparator P flag raised with A as clear source");

    timer_no_pin_a: assert property (
        (ce && mc.operating_mode_field == `MODE_TIMER) |=> !timer_io_pin_oe)
        else $error("pin driven in timer mode");

    initial_level_a: assert property (
        (on_rise && mc.operating_mode_field == `MODE_COMPARE
         && !(ce && run && a_hit)) ##1 ce [*2]
        |-> timer_io_pin_o == ($past(mc.output_control_bit, 2)
                              ^ $past(mc.output_polarity_bit, 2)))
        else $error("pin not at initial level after on-bit rise");

    full_duty_a: assert property (
        (ce && mc.operating_mode_field == `MODE_PWM
         && mc.pin_function_field == `PIN_FN_2 && duty >= period)
        |=> timer_io_pin_o == ($past(mc.output_control_bit) ^ $past(mc.output_polarity_bit)))
        else $error("pwm not at full duty");

    a_flag_cover: cover property (compare_a_flag);
    p_flag_cover: cover property (compare_p_flag);
    capture_cover: cover property (capture_now);
    pwm_cover: cover property (mc.operating_mode_field == `MODE_PWM && $rose(timer_io_pin_o));
endmodule

// File: test_standard_timer.sv
`timescale 1ns/1ps
`include "timer_defs.svh"
module test_standard_timer;
    import timer_pkg::*;
    logic        clk;
    logic        rst;
    logic        ce;
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        ext_pin;
    logic        sub_pin;
    logic        io_pin_i;
    logic        pin_o;
    logic        pin_oe;
    logic        flag_a;
    logic        flag_p;
    int          n_fail;
    int          n_tests;
    int          n_pflag = 0;

    standard_timer i_standard_timer (
        .clk                (clk),
        .rst                (rst),
        .ce                 (ce),
        .address            (address),
        .read               (read),
        .write              (write),
        .writedata          (writedata),
        .byteenable         (byteenable),
        .readdata           (readdata),
        .waitrequest        (waitrequest),
        .external_count_pin (ext_pin),
        .sub_clock_pin      (sub_pin),
        .timer_io_pin_i     (io_pin_i),
        .timer_io_pin_o     (pin_o),
        .timer_io_pin_oe    (pin_oe),
        .compare_a_flag     (flag_a),
        .compare_p_flag     (flag_p)
    );

    // 125 mhz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // running count of p flag pulses
    always @(posedge clk) begin
        if (flag_p === 1'b1) n_pflag <= n_pflag + 1;
    end

    // one avalon transfer, held until waitrequest is seen low
    task bus(input logic is_wr, input logic [4:0] adr, input logic [7:0] d, output logic [7:0] q);
        @(posedge clk);
        address <= adr;
        writedata <= {24'h0, d};
        read <= ~is_wr;
        write <= is_wr;
        do begin
            @(posedge clk);
        end while (waitrequest !== 1'b0);
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
    endtask

    task wr(input logic [4:0] adr, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, adr, d, q);
    endtask

    task rd(input logic [4:0] adr, output logic [7:0] q);
        bus(1'b0, adr, 8'h00, q);
    endtask

    task rd16(output logic [15:0] v);
        rd(`OFS_COUNTER_LOW, v[7:0]);
        rd(`OFS_COUNTER_HIGH, v[15:8]);
    endtask

    task set_a(input logic [15:0] v);
        wr(`OFS_COMPARE_A_LOW, v[7:0]);
        wr(`OFS_COMPARE_A_HIGH, v[15:8]);
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // cycles between two successive flag pulses
    task gap(input bit p, output int g);
        int n;
        n = 0;
        while ((p ? flag_p : flag_a) !== 1'b1 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        g = 0;
        do begin
            @(posedge clk);
            g++;
        end while ((p ? flag_p : flag_a) !== 1'b1 && g < 4000);
    endtask

    task t_regs;
        logic [7:0] q;
        rd(`OFS_COUNT_CONTROL, q);
        chk(16'(q), 16'(`RST_COUNT_CONTROL));
        rd(`OFS_MODE_CONTROL, q);
        chk(16'(q), 16'(`RST_MODE_CONTROL));
        rd(`OFS_COMPARE_A_HIGH, q);
        chk(16'(q), 16'(`RST_COMPARE));
        rd(5'h1c, q);
        chk(16'(q), 16'h0000);
        wr(`OFS_COUNT_CONTROL, 8'h07);
        rd(`OFS_COUNT_CONTROL, q);
        chk(16'(q), 16'h0000);
        wr(`OFS_COMPARE_A_LOW, 8'h5a);
        rd(`OFS_COMPARE_A_LOW, q);
        chk(16'(q), 16'h005a);
        $display("registers test done");
    endtask

    task t_onoff;
        logic [15:0] c1;
        logic [15:0] c2;
        wr(`OFS_COUNT_CONTROL, 8'h18);
        repeat (30) @(posedge clk);
        wr(`OFS_COUNT_CONTROL, 8'h10);
        rd16(c1);
        chk(16'(c1 > 16'd20), 16'h1);
        repeat (20) @(posedge clk);
        wr(`OFS_COUNTER_LOW, 8'h00);
        rd16(c2);
        chk(c2, c1);
        wr(`OFS_COUNT_CONTROL, 8'h18);
        wr(`OFS_COUNT_CONTROL, 8'h10);
        rd16(c2);
        chk(16'(c2 < 16'd8), 16'h1);
        // pause holds, release resumes from the held value
        wr(`OFS_COUNT_CONTROL, 8'h18);
        repeat (10) @(posedge clk);
        wr(`OFS_COUNT_CONTROL, 8'h98);
        rd16(c1);
        repeat (20) @(posedge clk);
        rd16(c2);
        chk(c2, c1);
        wr(`OFS_COUNT_CONTROL, 8'h18);
        repeat (20) @(posedge clk);
        wr(`OFS_COUNT_CONTROL, 8'h98);
        rd16(c2);
        chk(16'((c2 - c1) inside {[16'd20:16'd40]}), 16'h1);
        wr(`OFS_COUNT_CONTROL, 8'h00);
        $display("on off pause test done");
    endtask

    task t_clocks;
        logic [2:0]  sel [4] = '{3'h0, 3'h1, 3'h2, 3'h3};
        int          exp [4] = '{40, 10, 160, 640};
        logic [15:0] c;
        int          g;
        wr(`OFS_MODE_CONTROL, 8'hc1);
        set_a(16'h000a);
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_COUNT_CONTROL, {1'b0, sel[i], 1'b1, 3'h0});
            gap(1'b0, g);
            chk(16'(g), 16'(exp[i]));
            chk(16'(pin_oe), 16'h0);
            wr(`OFS_COUNT_CONTROL, 8'h00);
        end
        wr(`OFS_COUNT_CONTROL, 8'h58);
        repeat (50) @(posedge clk);
        wr(`OFS_COUNT_CONTROL, 8'h50);
        rd16(c);
        chk(c, 16'h0000);
        // external pin, rising then falling edges
        for (int s = 0; s < 2; s++) begin
            wr(`OFS_COUNT_CONTROL, s ? 8'h78 : 8'h68);
            repeat (5) begin
                ext_pin <= 1'b1;
                repeat (4) @(posedge clk);
                ext_pin <= 1'b0;
                repeat (4) @(posedge clk);
            end
            repeat (6) @(posedge clk);
            wr(`OFS_COUNT_CONTROL, s ? 8'h70 : 8'h60);
            rd16(c);
            chk(c, 16'h0005);
        end
        $display("clock select test done");
    endtask

    task t_clear;
        int g;
        int p0;
        wr(`OFS_COMPARE_P_HIGH, 8'h01);
        set_a(16'h0300);
        p0 = n_pflag;
        wr(`OFS_COUNT_CONTROL, 8'h18);
        gap(1'b0, g);
        chk(16'(g), 16'd768);
        chk(16'(n_pflag - p0), 16'h0);
        wr(`OFS_COUNT_CONTROL, 8'h00);
        wr(`OFS_MODE_CONTROL, 8'hc0);
        wr(`OFS_COUNT_CONTROL, 8'h18);
        gap(1'b1, g);
        chk(16'(g), 16'd256);
        wr(`OFS_COUNT_CONTROL, 8'h00);
        $display("clear source test done");
    endtask

    task t_pin;
        logic [1:0] fn [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
        logic       oc [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
        logic       e1 [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
        logic       e2 [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
        set_a(16'h000a);
        for (int i = 0; i < 4; i++) begin
            wr(`OFS_MODE_CONTROL, {2'h0, fn[i], oc[i], 3'b001});
            wr(`OFS_COUNT_CONTROL, 8'h18);
            repeat (3) @(posedge clk);
            chk(16'(pin_oe), 16'h1);
            chk(16'(pin_o), 16'(oc[i]));
            // one match per check, so a toggle is seen once
            while (flag_a !== 1'b1) @(posedge clk);
            repeat (3) @(posedge clk);
            chk(16'(pin_o), 16'(e1[i]));
            while (flag_a !== 1'b1) @(posedge clk);
            repeat (3) @(posedge clk);
            chk(16'(pin_o), 16'(e2[i]));
            wr(`OFS_COUNT_CONTROL, 8'h00);
        end
        wr(`OFS_MODE_CONTROL, 8'h05);
        wr(`OFS_COUNT_CONTROL, 8'h18);
        repeat (3) @(posedge clk);
        chk(16'(pin_o), 16'h1);
        wr(`OFS_COUNT_CONTROL, 8'h00);
        $display("compare output test done");
    endtask

    task t_pwm;
        logic ok;
        wr(`OFS_COMPARE_P_HIGH, 8'h01);
        set_a(16'h0200);
        for (int f = 0; f < 3; f++) begin
            wr(`OFS_MODE_CONTROL, {2'h2, 2'(f), 4'b1000});
            wr(`OFS_COUNT_CONTROL, 8'h18);
            repeat (3) @(posedge clk);
            ok = 1'b1;
            repeat (20) begin
                repeat (13) @(posedge clk);
                if (pin_o !== (f != 0)) ok = 1'b0;
            end
            chk(16'(ok), 16'h1);
            wr(`OFS_COUNT_CONTROL, 8'h00);
        end
        set_a(16'h0040);
        pwm_ones(8'ha8, 256, 64);
        set_a(16'h0400);
        pwm_ones(8'haa, 1024, 256);
        $display("pwm test done");
    endtask

    // active cycles over one whole pwm period
    task pwm_ones(input logic [7:0] m, input int span, input int exp);
        int n;
        wr(`OFS_MODE_CONTROL, m);
        wr(`OFS_COUNT_CONTROL, 8'h18);
        repeat (3) @(posedge clk);
        n = 0;
        repeat (span) begin
            @(posedge clk);
            if (pin_o === 1'b1) n++;
        end
        chk(16'(n), 16'(exp));
        wr(`OFS_COUNT_CONTROL, 8'h00);
    endtask

    // paused counter, rising pin edge copies it into compare a
    task t_capture;
        logic [15:0] c;
        logic [15:0] v;
        wr(`OFS_MODE_CONTROL, 8'h40);
        wr(`OFS_COUNT_CONTROL, 8'h18);
        repeat (10) @(posedge clk);
        wr(`OFS_COUNT_CONTROL, 8'h98);
        rd16(c);
        io_pin_i <= 1'b1;
        repeat (6) @(posedge clk);
        rd(`OFS_COMPARE_A_LOW, v[7:0]);
        rd(`OFS_COMPARE_A_HIGH, v[15:8]);
        chk(v, c);
        io_pin_i <= 1'b0;
        wr(`OFS_COUNT_CONTROL, 8'h00);
        $display("capture test done");
    endtask

    task end_sim;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    // watchdog against a hung bus or missing flag
    initial begin
        #200000;
        n_fail++;
        $display("ERROR at %0t: watchdog, got %h expected %h", $time, 1'b0, 1'b1);
        end_sim;
    end

    // main sequence
    initial begin
        n_fail = 0;
        n_tests = 0;
        rst = 1'b1;
        ce = 1'b1;
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0;
        byteenable = 4'h1;
        ext_pin = 1'b0;
        sub_pin = 1'b0;
        io_pin_i = 1'b0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_onoff;
        t_clocks;
        t_clear;
        t_pin;
        t_pwm;
        t_capture;
        end_sim;
    end
endmodule
